// >>> design/atf_cfg.svh
// register offsets, field positions and reset values for the trigger block
`ifndef ATF_CFG_SVH
`define ATF_CFG_SVH
`define ATF_OFS_CTRL0      4'h0
`define ATF_OFS_CTRL1      4'h1
`define ATF_OFS_TRIGNEG    4'h2
`define ATF_OFS_RESH       4'h3
`define ATF_OFS_RESL       4'h4
`define ATF_ADDR_W         12
`define ATF_RST_BYTE       8'h00
`define ATF_TRIG_HI        7
`define ATF_TRIG_LO        4
`define ATF_NEG_HI         3
`define ATF_NEG_LO         0
`define ATF_PCH_HI         6
`define ATF_PCH_LO         2
`define ATF_EN_BIT         0
`define ATF_GO_BIT         1
`define ATF_FMT_BIT        7
`define ATF_NREF_BIT       2
`define ATF_CTRL1_MASK     8'hF7
`define ATF_NEG_MAX_AN     4'hD
`define ATF_NEG_REF        4'hF
`define ATF_NEG_OFF        5'h10
`define ATF_RESP_OKAY      2'h0
`define ATF_RESP_SLVERR    2'h2
`define ATF_TRG_CAPTURE_COMPARE_UNIT_1       4'h1
`define ATF_TRG_CAPTURE_COMPARE_UNIT_2       4'h2
`define ATF_TRG_P1_PER     4'h4
`define ATF_TRG_P1_RISE    4'h5
`define ATF_TRG_P1_FALL    4'h6
`define ATF_TRG_P2_PER     4'h7
`define ATF_TRG_P2_RISE    4'h8
`define ATF_TRG_P2_FALL    4'h9
`define ATF_TRG_P3_PER     4'hA
`define ATF_TRG_P3_RISE    4'hB
`define ATF_TRG_P3_FALL    4'hC
`endif

// >>> design/atf_pkg.sv
// types shared by the trigger and result format block
package atf_pkg;
    // trigger event inputs from sibling units
    typedef struct packed {
        logic capture_compare_unit_1;
        logic capture_compare_unit_2;
        logic [2:0] pwm1;   // falling, rising, period
        logic [2:0] pwm2;
        logic [2:0] pwm3;
    } atf_trig_t;
    // conversion result handed in by the analog core
    typedef struct packed {
        logic        valid;
        logic        sign;
        logic [11:0] mag;
    } atf_result_t;
    // register read bus states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RESP = 2'b10
    } atf_bus_st_t;
endpackage

// >>> design/atf_top.sv
// converter trigger selection, input mux select and result formatting
`include "atf_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module atf_top #(
    parameter bit HAS_PWM3 = 1'b1   // third pwm unit present
) (
    // clock and reset
    input  wire logic                core_clk_i,
    input  wire logic                rst_n_i,
    // axi4-lite write address / data / response
    input  wire logic [`ATF_ADDR_W-1:0] s_awaddr_i,
    input  wire logic                s_awvalid_i,
    output logic                     s_awready_o,
    input  wire logic [31:0]         s_wdata_i,
    input  wire logic [3:0]          s_wstrb_i,
    input  wire logic                s_wvalid_i,
    output logic                     s_wready_o,
    output logic [1:0]               s_bresp_o,
    output logic                     s_bvalid_o,
    input  wire logic                s_bready_i,
    // axi4-lite read
    input  wire logic [`ATF_ADDR_W-1:0] s_araddr_i,
    input  wire logic                s_arvalid_i,
    output logic                     s_arready_o,
    output logic [31:0]              s_rdata_o,
    output logic [1:0]               s_rresp_o,
    output logic                     s_rvalid_o,
    input  wire logic                s_rready_i,
    // trigger events and converter core
    input  wire atf_pkg::atf_trig_t  trig_i,
    input  wire atf_pkg::atf_result_t result_i,
    output logic                     conv_start_o,
    output logic                     converter_enable_o,
    output logic [4:0]               positive_channel_select_o,
    output logic [4:0]               negative_mux_o,
    output logic                     negative_reference_select_o
);
    // register storage
    logic [7:0] ctrl0_ff;           // enable, go, channel, width mode
    logic [7:0] ctrl1_ff;           // format, clock, references
    logic [7:0] trigneg_ff;         // trigger and negative channel
    logic [7:0] resh_ff;            // result high byte
    logic [7:0] resl_ff;            // result low byte
    logic       trig_q_ff;          // previous selected trigger level
    logic       nxt_trig;           // selected trigger level now
    logic       trig_rise;          // rising edge of selected trigger
    // bus handshake state
    logic       aw_got_ff;
    logic       w_got_ff;
    logic [`ATF_ADDR_W-1:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0]  wstrb_ff;
    atf_pkg::atf_bus_st_t rd_st_ff;
    logic       wr_fire;            // both halves of a write held
    logic [7:0] wbyte;              // lane 0 of write data

    // word index of a byte address, or all ones when off grid
    function automatic logic [3:0] reg_idx(input logic [`ATF_ADDR_W-1:0] a);
        if (a[1:0] != 2'h0 || a[`ATF_ADDR_W-1:5] != '0) begin
            reg_idx = 4'hF;
        end else begin
            reg_idx = a[5:2];
        end
    endfunction

    // trigger mux; reserved and zero codes give no source
    always_comb begin
        unique case (trigneg_ff[`ATF_TRIG_HI:`ATF_TRIG_LO])
            `ATF_TRG_CAPTURE_COMPARE_UNIT_1:    nxt_trig = trig_i.capture_compare_unit_1;
            `ATF_TRG_CAPTURE_COMPARE_UNIT_2:    nxt_trig = trig_i.capture_compare_unit_2;
            `ATF_TRG_P1_PER:  nxt_trig = trig_i.pwm1[0];
            `ATF_TRG_P1_RISE: nxt_trig = trig_i.pwm1[1];
            `ATF_TRG_P1_FALL: nxt_trig = trig_i.pwm1[2];
            `ATF_TRG_P2_PER:  nxt_trig = trig_i.pwm2[0];
            `ATF_TRG_P2_RISE: nxt_trig = trig_i.pwm2[1];
            `ATF_TRG_P2_FALL: nxt_trig = trig_i.pwm2[2];
            `ATF_TRG_P3_PER:  nxt_trig = HAS_PWM3 & trig_i.pwm3[0];
            `ATF_TRG_P3_RISE: nxt_trig = HAS_PWM3 & trig_i.pwm3[1];
            `ATF_TRG_P3_FALL: nxt_trig = HAS_PWM3 & trig_i.pwm3[2];
            default:          nxt_trig = 1'b0;
        endcase
    end

    // edge detect on the selected source
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            trig_q_ff <= 1'b0;
        end else begin
            trig_q_ff <= nxt_trig;
        end
    end
    assign trig_rise = nxt_trig & ~trig_q_ff;

    // write channel capture; address and data in either order
    assign wr_fire = aw_got_ff & w_got_ff;
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            aw_got_ff <= 1'b0;
            w_got_ff  <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff  <= '0;
            wstrb_ff  <= 4'h0;
            s_bvalid_o <= 1'b0;
            s_bresp_o  <= `ATF_RESP_OKAY;
        end else begin
            if (s_awvalid_i && s_awready_o) begin
                aw_got_ff <= 1'b1;
                awaddr_ff <= s_awaddr_i;
            end
            if (s_wvalid_i && s_wready_o) begin
                w_got_ff <= 1'b1;
                wdata_ff <= s_wdata_i;
                wstrb_ff <= s_wstrb_i;
            end
            if (wr_fire) begin
                aw_got_ff  <= 1'b0;
                w_got_ff   <= 1'b0;
                s_bvalid_o <= 1'b1;
                s_bresp_o  <= (reg_idx(awaddr_ff) > `ATF_OFS_RESL)
                              ? `ATF_RESP_SLVERR : `ATF_RESP_OKAY;
            end else if (s_bvalid_o && s_bready_i) begin
                s_bvalid_o <= 1'b0;
            end
        end
    end
    // ready only while that half is not yet held and no response pends
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            s_awready_o <= 1'b0;
            s_wready_o  <= 1'b0;
        end else begin
            s_awready_o <= ~s_bvalid_o & ~wr_fire & ~aw_got_ff
                           & ~(s_awvalid_i & s_awready_o);
            s_wready_o  <= ~s_bvalid_o & ~wr_fire & ~w_got_ff
                           & ~(s_wvalid_i & s_wready_o);
        end
    end
    assign wbyte = wdata_ff[7:0];

    // control registers; go set by trigger wins over software clear
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            ctrl0_ff   <= `ATF_RST_BYTE;
            ctrl1_ff   <= `ATF_RST_BYTE;
            trigneg_ff <= `ATF_RST_BYTE;
        end else begin
            if (wr_fire && wstrb_ff[0]) begin
                unique case (reg_idx(awaddr_ff))
                    `ATF_OFS_CTRL0:   ctrl0_ff <= wbyte;
                    `ATF_OFS_CTRL1:   ctrl1_ff <= wbyte & `ATF_CTRL1_MASK;
                    `ATF_OFS_TRIGNEG: trigneg_ff <= wbyte;
                    default: ;
                endcase
            end
            // completion clears go unless a new trigger arrives
            if (result_i.valid && ctrl0_ff[`ATF_GO_BIT]) begin
                ctrl0_ff[`ATF_GO_BIT] <= 1'b0;
            end
            if (trig_rise && ctrl0_ff[`ATF_EN_BIT]) begin
                ctrl0_ff[`ATF_GO_BIT] <= 1'b1;
            end
        end
    end

    // result bytes: no reset, loaded together at completion
    always_ff @(posedge core_clk_i) begin
        if (result_i.valid && ctrl0_ff[`ATF_GO_BIT]) begin
            if (ctrl1_ff[`ATF_FMT_BIT]) begin
                resh_ff <= {{4{result_i.sign}},
                            result_i.mag[11:8]};
                resl_ff <= result_i.mag[7:0];
            end else begin
                resh_ff <= result_i.mag[11:4];
                resl_ff <= {result_i.mag[3:0], 3'h0,
                            result_i.sign};
            end
        end else if (wr_fire && wstrb_ff[0]) begin
            if (reg_idx(awaddr_ff) == `ATF_OFS_RESH) begin
                resh_ff <= wbyte;
            end
            if (reg_idx(awaddr_ff) == `ATF_OFS_RESL) begin
                resl_ff <= wbyte;
            end
        end
    end

    // read channel: one read at a time, data one cycle after address
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            rd_st_ff    <= atf_pkg::ST_IDLE;
            s_arready_o <= 1'b0;
            s_rvalid_o  <= 1'b0;
            s_rdata_o   <= '0;
            s_rresp_o   <= `ATF_RESP_OKAY;
        end else begin
            unique case (rd_st_ff)
                atf_pkg::ST_IDLE: begin
                    s_arready_o <= ~(s_arvalid_i & s_arready_o);
                    if (s_arvalid_i && s_arready_o) begin
                        rd_st_ff   <= atf_pkg::ST_RESP;
                        s_rvalid_o <= 1'b1;
                        s_rresp_o  <= `ATF_RESP_OKAY;
                        unique case (reg_idx(s_araddr_i))
                            `ATF_OFS_CTRL0:   s_rdata_o <= {24'h0, ctrl0_ff};
                            `ATF_OFS_CTRL1:   s_rdata_o <= {24'h0, ctrl1_ff};
                            `ATF_OFS_TRIGNEG: s_rdata_o <= {24'h0, trigneg_ff};
                            `ATF_OFS_RESH:    s_rdata_o <= {24'h0, resh_ff};
                            `ATF_OFS_RESL:    s_rdata_o <= {24'h0, resl_ff};
                            default: begin
                                s_rdata_o <= '0;
                                s_rresp_o <= `ATF_RESP_SLVERR;
                            end
                        endcase
                    end
                end
                atf_pkg::ST_RESP: begin
                    if (s_rready_i) begin
                        s_rvalid_o  <= 1'b0;
                        rd_st_ff    <= atf_pkg::ST_IDLE;
                        s_arready_o <= 1'b1;
                    end
                end
            endcase
        end
    end

    // converter side outputs, all registered
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            conv_start_o                <= 1'b0;
            converter_enable_o          <= 1'b0;
            positive_channel_select_o   <= 5'h0;
            negative_mux_o              <= `ATF_NEG_OFF;
            negative_reference_select_o <= 1'b0;
        end else begin
            conv_start_o       <= trig_rise & ctrl0_ff[`ATF_EN_BIT];
            converter_enable_o <= ctrl0_ff[`ATF_EN_BIT];
            positive_channel_select_o <=
                ctrl0_ff[`ATF_PCH_HI:`ATF_PCH_LO];
            negative_reference_select_o <= ctrl1_ff[`ATF_NREF_BIT];
            if (!ctrl0_ff[`ATF_EN_BIT]) begin
                negative_mux_o <= `ATF_NEG_OFF;
            end else begin
                negative_mux_o <= {1'b0,
                    trigneg_ff[`ATF_NEG_HI:`ATF_NEG_LO]};
            end
        end
    end

    // assertions
    a_trig_sets_go: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        (trig_rise && ctrl0_ff[`ATF_EN_BIT]) |=> ctrl0_ff[`ATF_GO_BIT])
        else $error("trigger edge did not set go");
    a_reserved_no_start: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        (trigneg_ff[7:4] == 4'h3 || trigneg_ff[7:4] > 4'hC
         || trigneg_ff[7:4] == 4'h0) |-> !trig_rise)
        else $error("reserved trigger code started conversion");
    a_capture_compare_unit_1_select: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        (trigneg_ff[7:4] == 4'h1) |-> (nxt_trig == trig_i.capture_compare_unit_1))
        else $error("code one not routed to first capture unit");
    a_pwm2_fall: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        (trigneg_ff[7:4] == 4'h9) |-> (nxt_trig == trig_i.pwm2[2]))
        else $error("code nine not routed to pwm2 falling");
    a_pwm1_rise: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        (trigneg_ff[7:4] == 4'h5) |-> (nxt_trig == trig_i.pwm1[1]))
        else $error("code five not routed to pwm1 rising");
    a_mux_off: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        $past(!ctrl0_ff[0]) && $past(rst_n_i) |-> negative_mux_o[4])
        else $error("mux connected while converter disabled");
    a_fmt0_layout: assert property (@(posedge core_clk_i)
        (result_i.valid && ctrl0_ff[1] && !ctrl1_ff[7] && rst_n_i)
        |=> resl_ff == {$past(result_i.mag[3:0]), 3'h0,
                        $past(result_i.sign)})
        else $error("format 0 low byte wrong");
    a_fmt1_layout: assert property (@(posedge core_clk_i)
        (result_i.valid && ctrl0_ff[1] && ctrl1_ff[7] && rst_n_i)
        |=> resh_ff == {{4{$past(result_i.sign)}},
                        $past(result_i.mag[11:8])})
        else $error("format 1 high byte wrong");
    a_reset_clear: assert property (@(posedge core_clk_i)
        !rst_n_i |=> trigneg_ff == 8'h00)
        else $error("trigger register not cleared by reset");
    a_fmt0_high: assert property (@(posedge core_clk_i)
        (result_i.valid && ctrl0_ff[`ATF_GO_BIT]
         && !ctrl1_ff[`ATF_FMT_BIT] && rst_n_i)
        |=> resh_ff == $past(result_i.mag[11:4]))
        else $error("format 0 high byte wrong");
    a_fmt0_zero: assert property (@(posedge core_clk_i)
        (result_i.valid && ctrl0_ff[`ATF_GO_BIT]
         && !ctrl1_ff[`ATF_FMT_BIT] && rst_n_i)
        |=> resl_ff[3:1] == 3'h0)
        else $error("format 0 extended low bits not zero");
    a_fmt1_low: assert property (@(posedge core_clk_i)
        (result_i.valid && ctrl0_ff[`ATF_GO_BIT]
         && ctrl1_ff[`ATF_FMT_BIT] && rst_n_i)
        |=> resl_ff == $past(result_i.mag[7:0]))
        else $error("format 1 low byte wrong");
    a_neg_chan: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        $past(ctrl0_ff[`ATF_EN_BIT]) && $past(rst_n_i)
        |-> negative_mux_o == {1'b0,
            $past(trigneg_ff[`ATF_NEG_HI:`ATF_NEG_LO])})
        else $error("negative channel not routed");
    a_start_pulse: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        (trig_rise && ctrl0_ff[`ATF_EN_BIT]) |=> conv_start_o)
        else $error("trigger edge gave no start pulse");
    a_done_clears: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        (result_i.valid && ctrl0_ff[`ATF_GO_BIT]
         && !(trig_rise && ctrl0_ff[`ATF_EN_BIT]))
        |=> !ctrl0_ff[`ATF_GO_BIT])
        else $error("completion did not clear go");
    a_capture_compare_unit_2_select: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        (trigneg_ff[`ATF_TRIG_HI:`ATF_TRIG_LO] == `ATF_TRG_CAPTURE_COMPARE_UNIT_2)
        |-> (nxt_trig == trig_i.capture_compare_unit_2))
        else $error("code two not routed to second capture unit");
    a_pwm2_per: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        (trigneg_ff[`ATF_TRIG_HI:`ATF_TRIG_LO] == `ATF_TRG_P2_PER)
        |-> (nxt_trig == trig_i.pwm2[0]))
        else $error("code seven not routed to pwm2 period");
    a_pwm3_fall: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        (trigneg_ff[`ATF_TRIG_HI:`ATF_TRIG_LO] == `ATF_TRG_P3_FALL)
        |-> (nxt_trig == (HAS_PWM3 & trig_i.pwm3[2])))
        else $error("code twelve not routed to pwm3 falling");
    c_fmt0_load: cover property (@(posedge core_clk_i)
        disable iff (!rst_n_i) result_i.valid && ctrl0_ff[`ATF_GO_BIT]
        && !ctrl1_ff[`ATF_FMT_BIT]);
    c_go_race: cover property (@(posedge core_clk_i)
        disable iff (!rst_n_i) result_i.valid && ctrl0_ff[`ATF_GO_BIT]
        && trig_rise && ctrl0_ff[`ATF_EN_BIT]);
    c_auto_start: cover property (@(posedge core_clk_i)
        disable iff (!rst_n_i) conv_start_o);
    c_fmt1_load: cover property (@(posedge core_clk_i)
        disable iff (!rst_n_i) result_i.valid && ctrl0_ff[1] && ctrl1_ff[7]);
    c_neg_ref: cover property (@(posedge core_clk_i)
        disable iff (!rst_n_i) negative_mux_o == 5'h0F);
endmodule
`default_nettype wire

// >>> verif/atf_partner.sv
// trigger source and converter core model facing the block
`timescale 1ns/1ns
`default_nettype none
module atf_partner (
    // clock and conversion start from the block
    input  wire logic                 core_clk_i,
    input  wire logic                 conv_start_i,
    // trigger events and finished conversion result
    output var atf_pkg::atf_trig_t    trig_o,
    output var atf_pkg::atf_result_t  result_o
);
    logic        res_sign;  // sign of next reported result
    logic [11:0] res_mag;   // magnitude of next reported result
    int          cnt;       // cycles left until conversion end

    initial begin
        trig_o = '0;
        result_o = '0;
        res_sign = 1'b0;
        res_mag = 12'h000;
        cnt = 0;
    end

    // pulse one source: 0 capture_compare_unit_1, 1 capture_compare_unit_2, 2..10 pwm units (period, rise, fall)
    task automatic fire(input int src);
        int pos;
        pos = (src < 2) ? 10 - src : 6 - 3 * ((src - 2) / 3) + (src - 2) % 3;
        @(posedge core_clk_i);
        trig_o <= 11'(1 << pos);  // slow event, held four cycles
        repeat (4) @(posedge core_clk_i);
        trig_o <= '0;
        repeat (4) @(posedge core_clk_i);
    endtask

    // answer each start with a result pulse; result lines churn otherwise
    always @(posedge core_clk_i) begin
        if (conv_start_i) begin
            cnt <= 6;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
        if (cnt == 1) begin
            result_o <= {1'b1, res_sign, res_mag};
        end else begin
            result_o <= {1'b0, 13'($urandom)};
        end
    end
endmodule
`default_nettype wire

// >>> verif/test_adc_trigger_and_result_format.sv
// self-checking bench for the trigger and result format block
`timescale 1ns/1ns
`default_nettype none
module test_adc_trigger_and_result_format;
    localparam logic [11:0] A_C0 = 12'h000;  // control 0
    localparam logic [11:0] A_C1 = 12'h004;  // control 1
    localparam logic [11:0] A_TN = 12'h008;  // trigger / negative channel
    localparam logic [11:0] A_RH = 12'h00C;  // result high
    localparam logic [11:0] A_RL = 12'h010;  // result low
    localparam logic [11:0] A_NO = 12'h014;  // unmapped
    logic        core_clk_i, rst_n_i;        // clock and reset
    logic [11:0] awaddr, araddr;             // bus addresses
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata, rdata;               // bus data
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    atf_pkg::atf_trig_t   trig;              // events from partner
    atf_pkg::atf_result_t res;               // result from partner
    logic        start, en, nref;            // block outputs
    logic [4:0]  pchan, negmux;
    int          error_cnt = 0, cmp_count = 0, cyc = 0, starts = 0;
    logic [33:0] expq[$];                    // expected {resp, data}

    atf_top atf_top_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .s_awaddr_i(awaddr), .s_awvalid_i(awvalid), .s_awready_o(awready),
        .s_wdata_i(wdata), .s_wstrb_i(wstrb), .s_wvalid_i(wvalid),
        .s_wready_o(wready), .s_bresp_o(bresp), .s_bvalid_o(bvalid),
        .s_bready_i(bready), .s_araddr_i(araddr), .s_arvalid_i(arvalid),
        .s_arready_o(arready), .s_rdata_o(rdata), .s_rresp_o(rresp),
        .s_rvalid_o(rvalid), .s_rready_i(rready), .trig_i(trig),
        .result_i(res), .conv_start_o(start), .converter_enable_o(en),
        .positive_channel_select_o(pchan), .negative_mux_o(negmux),
        .negative_reference_select_o(nref));
    atf_partner atf_partner_inst (.core_clk_i(core_clk_i),
        .conv_start_i(start), .trig_o(trig), .result_o(res));

    initial begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end

    // count and report one comparison
    task automatic chk(input logic [33:0] got, exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // bus write of one byte, response code checked
    task automatic wr(input logic [11:0] a, input logic [7:0] d,
                      input logic [1:0] er);
        @(posedge core_clk_i);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge core_clk_i);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk({32'h0, bresp}, {32'h0, er}, "write response");
    endtask

    // bus read; expectation noted for the watcher
    task automatic rd(input logic [11:0] a, input logic [7:0] d,
                      input logic [1:0] er);
        expq.push_back({er, 24'h000000, d});
        @(posedge core_clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge core_clk_i);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
    endtask

    task automatic do_reset(input int n);
        @(posedge core_clk_i);
        rst_n_i <= 1'b0;
        repeat (n) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
    endtask

    // source index a trigger code selects, -1 for none
    function automatic int src_of(input int code);
        if (code == 1 || code == 2) return code - 1;
        if (code >= 4 && code <= 12) return code - 2;
        return -1;
    endfunction

    // watcher: read answers against notes, start pulses, hang limit
    always @(posedge core_clk_i) begin
        cyc++;
        if (start === 1'b1) starts++;
        if (rvalid && rready) begin
            if (expq.size() == 0) chk(34'h0, 34'h1, "stray read answer");
            else chk({rresp, rdata}, expq.pop_front(), "read answer");
        end
        if (cyc == 20000) begin
            error_cnt++;
            give_verdict();
        end
    end

    initial begin
        int s0, nib;
        logic [11:0] m;
        logic sg, f;
        rst_n_i = 1'b0;
        {awaddr, araddr, wdata, awvalid, wvalid, bready} = '0;
        {arvalid, rready} = '0;
        wstrb = 4'hF;
        void'($urandom(32'hCF7E));
        do_reset(6);
        rd(A_TN, 8'h00, 2'h0);
        rd(A_C1, 8'h00, 2'h0);
        wr(A_TN, 8'hA5, 2'h0);
        rd(A_TN, 8'hA5, 2'h0);
        wr(A_C1, 8'hFF, 2'h0);
        rd(A_C1, 8'hF7, 2'h0);
        chk({33'h0, nref}, 34'h1, "negative reference select");
        rd(A_NO, 8'h00, 2'h2);
        wr(A_NO, 8'h5A, 2'h2);
        // negative channel with converter off and on
        for (int k = 0; k < 5; k++) begin
            nib = (k == 4) ? 15 : $urandom_range(13);
            wr(A_C0, 8'h00, 2'h0);
            wr(A_TN, 8'(nib), 2'h0);
            repeat (2) @(posedge core_clk_i);
            chk({29'h0, negmux}, 34'h10, "mux while off");
            wr(A_C0, 8'h49, 2'h0);
            repeat (2) @(posedge core_clk_i);
            chk({29'h0, negmux}, 34'(nib), "mux while on");
            chk({28'h0, pchan, en}, 34'h25, "enable and channel");
        end
        // every trigger code against every source
        for (int c = 0; c < 16; c++) begin
            wr(A_TN, {c[3:0], 4'h0}, 2'h0);
            for (int s = 0; s < 11; s++) begin
                s0 = starts;
                atf_partner_inst.fire(s);
                chk(34'(starts - s0), 34'(src_of(c) == s), "starts");
            end
        end
        wr(A_C0, 8'h00, 2'h0);
        s0 = starts;
        atf_partner_inst.fire(0);
        chk(34'(starts - s0), 34'h0, "start while off");
        // result layouts in both formats
        wr(A_TN, 8'h10, 2'h0);
        wr(A_C0, 8'h01, 2'h0);
        repeat (20) @(posedge core_clk_i);  // acquisition wait
        for (int k = 0; k < 6; k++) begin
            m = 12'($urandom);
            sg = 1'($urandom);
            f = k[0];
            atf_partner_inst.res_mag = m;
            atf_partner_inst.res_sign = sg;
            wr(A_C1, {f, 7'h00}, 2'h0);
            atf_partner_inst.fire(0);
            repeat (8) @(posedge core_clk_i);
            rd(A_RH, f ? {{4{sg}}, m[11:8]} : m[11:4], 2'h0);
            rd(A_RL, f ? m[7:0] : {m[3:0], 3'b000, sg}, 2'h0);
        end
        // result high byte writable and kept over a reset
        wr(A_RH, 8'h3C, 2'h0);
        rd(A_RH, 8'h3C, 2'h0);
        wr(A_TN, 8'h5F, 2'h0);
        do_reset(2);
        rd(A_TN, 8'h00, 2'h0);
        rd(A_RH, 8'h3C, 2'h0);
        chk({29'h0, negmux}, 34'h10, "mux after reset");
        repeat (2) @(posedge core_clk_i);
        give_verdict();
    end
endmodule
`default_nettype wire
